// ===== src/serial_if_consts.svh
// constants for the single-master serial interface: offsets, bits, timing
`ifndef SERIAL_IF_CONSTS_SVH
`define SERIAL_IF_CONSTS_SVH

`define SER_OFF_DATA        12'h000
`define SER_OFF_PROTO       12'h004
`define SER_OFF_XFER        12'h008

`define SER_PROTO_VARIANT   0
`define SER_PROTO_ENABLE    1
`define SER_PROTO_STOP      2
`define SER_PROTO_START     3

`define SER_XFER_BUSY       0
`define SER_XFER_ACKMISS    1
`define SER_XFER_VERIFY     2
`define SER_XFER_DIR        3

`define SER_CORE_PERIOD_NS  4
`define SER_BIT_PERIOD_NS   16000
`define SER_QTR_CYCLES      ((`SER_BIT_PERIOD_NS / 4) / `SER_CORE_PERIOD_NS)
`define SER_FILT_LEN        3
`define SER_LAST_BIT        3'h7
`define SER_PH_LOW          2'h0
`define SER_PH_RISE         2'h2
`define SER_PH_HIGH         2'h3

`endif

// ===== src/serial_if_pkg.sv
// types shared by the single-master serial interface
package serial_if_pkg;

    typedef enum logic [1:0]
    {
        MODE_OFF   = 2'h0,
        MODE_SHIFT = 2'h1,
        MODE_I2C   = 2'h2,
        MODE_3WIRE = 2'h3
    } ser_mode_t;

    typedef enum
    {
        ST_IDLE,
        ST_START,
        ST_BIT,
        ST_ACK,
        ST_STOP
    } ser_state_t;

    // open-drain pin: oe high while the pin is pulled low
    typedef struct packed
    {
        logic o;
        logic oe;
    } pin_drive_t;

endpackage

// ===== src/serial_if.sv
// single-master serial interface (three-wire, i2c, shift) with apb slave
`timescale 1ns/100ps
`include "serial_if_consts.svh"

module serial_if
#(
    parameter int QTR_CYCLES = `SER_QTR_CYCLES,
    parameter int FILT_LEN   = `SER_FILT_LEN
)
(
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      port_c_line_0,
    input  wire logic                      port_c_line_1,
    input  wire logic                      port_c_line_3,
    input  wire logic                      scl_i,
    input  wire logic                      sda_i,
    output serial_if_pkg::pin_drive_t      scl_pin,
    output serial_if_pkg::pin_drive_t      sda_pin,
    output serial_if_pkg::pin_drive_t      serial_frame_enable_line,
    output logic                           vsync_irq_enable
);

    generate
        if (QTR_CYCLES < 4 || QTR_CYCLES > 4096 || FILT_LEN < 2)
        begin : g_bad_param
            $error("serial_if: unsupported QTR_CYCLES or FILT_LEN");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // registers and state

    logic [7:0]                shift_q;
    logic                      variant_q;
    logic                      bus_protocol_enable_q;
    logic                      start_request_q;
    logic                      stop_request_q;
    logic                      transfer_direction_alt_q;
    logic                      verify_q;
    logic                      ack_missing_q;
    logic                      byte_busy_q;
    logic                      vsync_en_q;
    serial_if_pkg::ser_state_t state_q;
    logic [11:0]               qcnt_q;
    logic [1:0]                phase_q;
    logic [2:0]                bit_q;
    logic                      scl_hw_q;
    logic                      sda_hw_q;
    logic                      sen_hw_q;
    logic                      pready_q;
    logic [31:0]               prdata_q;
    logic                      pslverr_q;

    serial_if_pkg::ser_mode_t  mode;
    logic                      bus_mode;
    logic                      access;
    logic                      wr_en;
    logic                      data_blocked;
    logic                      busy_set;

    assign mode     = serial_if_pkg::ser_mode_t'({bus_protocol_enable_q,
                                                  variant_q});
    assign bus_mode = bus_protocol_enable_q;
    assign access   = psel && penable && !pready_q;
    assign wr_en    = psel && penable && pready_q && pwrite;
    assign data_blocked = byte_busy_q && (paddr == `SER_OFF_DATA);
    assign busy_set = wr_en && paddr == `SER_OFF_XFER &&
                      pwdata[`SER_XFER_BUSY] && !byte_busy_q &&
                      mode != serial_if_pkg::MODE_OFF;

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer registered

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= access;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            if (access)
            begin
                case (paddr)
                    `SER_OFF_DATA:
                    begin
                        pslverr_q <= data_blocked;
                        if (!data_blocked && !pwrite)
                            prdata_q <= {24'h00_0000, shift_q};
                    end
                    `SER_OFF_PROTO:
                        prdata_q <= {28'h000_0000, start_request_q,
                                     stop_request_q, bus_protocol_enable_q,
                                     variant_q};
                    `SER_OFF_XFER:
                        prdata_q <= {28'h000_0000, 1'b0, verify_q,
                                     ack_missing_q, byte_busy_q};
                    default:
                        pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            variant_q             <= 1'b0;
            bus_protocol_enable_q <= 1'b0;
            start_request_q       <= 1'b0;
            stop_request_q        <= 1'b0;
        end
        else if (wr_en && paddr == `SER_OFF_PROTO)
        begin
            variant_q       <= pwdata[`SER_PROTO_VARIANT];
            start_request_q <= pwdata[`SER_PROTO_START];
            stop_request_q  <= pwdata[`SER_PROTO_STOP];
            bus_protocol_enable_q <= pwdata[`SER_PROTO_ENABLE] ||
                                     pwdata[`SER_PROTO_START] ||
                                     pwdata[`SER_PROTO_STOP];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            transfer_direction_alt_q <= 1'b0;
            vsync_en_q               <= 1'b0;
        end
        else if (wr_en && paddr == `SER_OFF_XFER)
        begin
            transfer_direction_alt_q <= pwdata[`SER_XFER_DIR];
            vsync_en_q <= pwdata[`SER_XFER_VERIFY];
        end
    end

    assign vsync_irq_enable = vsync_en_q;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers and glitch filters

    logic [1:0]          scl_sync_q;
    logic [1:0]          sda_sync_q;
    logic [FILT_LEN-1:0] scl_hist_q;
    logic [FILT_LEN-1:0] sda_hist_q;
    logic                scl_f_q;
    logic                sda_f_q;

    // a level only moves once it has been stable for the whole history
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_hist_q <= '1;
            sda_hist_q <= '1;
            scl_f_q    <= 1'b1;
            sda_f_q    <= 1'b1;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_hist_q <= {scl_hist_q[FILT_LEN-2:0], scl_sync_q[1]};
            sda_hist_q <= {sda_hist_q[FILT_LEN-2:0], sda_sync_q[1]};
            if (&scl_hist_q || ~|scl_hist_q)
                scl_f_q <= scl_hist_q[0];
            if (&sda_hist_q || ~|sda_hist_q)
                sda_f_q <= sda_hist_q[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit timing: four quarters per bit, stretched in i2c and three-wire modes while clock held low

    logic tick;
    logic stretch;
    logic advance;

    assign tick    = qcnt_q == 12'(QTR_CYCLES - 1);
    // only a clock we have released can be held low by a peripheral;
    // the start sequence drives it low itself in its last quarter
    assign stretch = bus_mode && phase_q == `SER_PH_HIGH && scl_hw_q &&
                     !scl_f_q &&
                     state_q != serial_if_pkg::ST_IDLE;
    assign advance = tick && !stretch;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            qcnt_q <= 12'h000;
        else if (state_q == serial_if_pkg::ST_IDLE || advance)
            qcnt_q <= 12'h000;
        else if (!tick)
            qcnt_q <= qcnt_q + 12'h001;
    end

    ////////////////////////////////////////////////////////////////////////
    // byte sequencer

    logic last_q;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q     <= serial_if_pkg::ST_IDLE;
            phase_q     <= 2'h0;
            bit_q       <= 3'h0;
            byte_busy_q <= 1'b0;
            last_q      <= 1'b0;
        end
        else
        begin
            last_q <= 1'b0;
            case (state_q)
                serial_if_pkg::ST_IDLE:
                    if (busy_set)
                    begin
                        byte_busy_q <= 1'b1;
                        phase_q     <= 2'h0;
                        bit_q       <= 3'h0;
                        state_q     <= (bus_mode && start_request_q) ?
                                       serial_if_pkg::ST_START :
                                       serial_if_pkg::ST_BIT;
                    end
                serial_if_pkg::ST_START:
                    if (advance)
                    begin
                        phase_q <= phase_q + 2'h1;
                        if (phase_q == `SER_PH_HIGH)
                            state_q <= serial_if_pkg::ST_BIT;
                    end
                serial_if_pkg::ST_BIT:
                    if (advance)
                    begin
                        phase_q <= phase_q + 2'h1;
                        if (phase_q == `SER_PH_HIGH)
                        begin
                            bit_q <= bit_q + 3'h1;
                            if (bit_q == `SER_LAST_BIT)
                            begin
                                if (bus_mode)
                                    state_q <= serial_if_pkg::ST_ACK;
                                else
                                    last_q <= 1'b1;
                            end
                        end
                    end
                serial_if_pkg::ST_ACK:
                    if (advance)
                    begin
                        phase_q <= phase_q + 2'h1;
                        if (phase_q == `SER_PH_HIGH)
                        begin
                            if (stop_request_q)
                                state_q <= serial_if_pkg::ST_STOP;
                            else
                                last_q <= 1'b1;
                        end
                    end
                serial_if_pkg::ST_STOP:
                    if (advance)
                    begin
                        phase_q <= phase_q + 2'h1;
                        if (phase_q == `SER_PH_HIGH)
                            last_q <= 1'b1;
                    end
                default:
                    state_q <= serial_if_pkg::ST_IDLE;
            endcase
            if (last_q)
            begin
                state_q     <= serial_if_pkg::ST_IDLE;
                byte_busy_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shift register, verify and acknowledge flags

    logic sample;

    assign sample = advance && phase_q == `SER_PH_HIGH;

    always_ff @(posedge core_clk)
    begin
        if (wr_en && !data_blocked && paddr == `SER_OFF_DATA)
            shift_q <= pwdata[7:0];
        else if (sample && state_q == serial_if_pkg::ST_BIT)
            shift_q <= {shift_q[6:0], sda_f_q};
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            verify_q <= 1'b0;
        else if (busy_set)
            verify_q <= 1'b1;
        else if (sample && state_q == serial_if_pkg::ST_BIT &&
                 sda_f_q != sda_hw_q)
            verify_q <= 1'b0;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ack_missing_q <= 1'b0;
        else if (busy_set)
            ack_missing_q <= 1'b0;
        else if (sample && state_q == serial_if_pkg::ST_ACK &&
                 transfer_direction_alt_q && sda_f_q)
            ack_missing_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // line drive, registered; in bit and ack states sda held through the quarter scl falls

    logic scl_d;
    logic sda_d;
    logic sen_d;
    logic sbus;

    assign sbus = mode == serial_if_pkg::MODE_3WIRE;

    always_comb
    begin
        scl_d = 1'b1;
        sda_d = 1'b1;
        sen_d = 1'b1;
        case (state_q)
            serial_if_pkg::ST_START:
            begin
                scl_d = phase_q < `SER_PH_RISE;
                sda_d = sbus || phase_q == `SER_PH_LOW;
                sen_d = !sbus || phase_q != 2'h1;
            end
            serial_if_pkg::ST_BIT:
            begin
                scl_d = phase_q >= `SER_PH_RISE;
                if (phase_q == `SER_PH_LOW)
                    sda_d = sda_hw_q;
                else
                    sda_d = !transfer_direction_alt_q || shift_q[7];
            end
            serial_if_pkg::ST_ACK:
            begin
                scl_d = phase_q >= `SER_PH_RISE;
                if (phase_q == `SER_PH_LOW)
                    sda_d = sda_hw_q;
                else
                    sda_d = transfer_direction_alt_q ||
                            stop_request_q;
            end
            serial_if_pkg::ST_STOP:
            begin
                scl_d = phase_q >= `SER_PH_RISE;
                // stop edge waits until the clock is seen high on the pin
                sda_d = sbus || (phase_q == `SER_PH_HIGH && scl_f_q);
                sen_d = !sbus || (phase_q == `SER_PH_HIGH && scl_f_q);
            end
            default:
            begin
                scl_d = 1'b1;
                sda_d = 1'b1;
                sen_d = 1'b1;
            end
        endcase
        // phase has already wrapped here: release at once, no stray pulse
        if (last_q)
        begin
            scl_d = 1'b1;
            sda_d = 1'b1;
            sen_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            scl_hw_q <= 1'b1;
            sda_hw_q <= 1'b1;
            sen_hw_q <= 1'b1;
        end
        else
        begin
            scl_hw_q <= scl_d;
            sda_hw_q <= sda_d;
            sen_hw_q <= sen_d;
        end
    end

    // open drain: port output and serial output both must be high to release
    assign scl_pin.o   = 1'b0;
    assign scl_pin.oe  = !(scl_hw_q && port_c_line_0);
    assign sda_pin.o   = 1'b0;
    assign sda_pin.oe  = !(sda_hw_q && port_c_line_1);
    assign serial_frame_enable_line.o  = 1'b0;
    assign serial_frame_enable_line.oe =
        !((sen_hw_q || !sbus) && port_c_line_3);

    ////////////////////////////////////////////////////////////////////////
    // checks

    busy_clears_a : assert property (@(posedge core_clk) disable iff (rst)
        last_q |=> !byte_busy_q && state_q == serial_if_pkg::ST_IDLE)
        else $error("busy did not clear at end of byte");

    data_block_a : assert property (@(posedge core_clk) disable iff (rst)
        byte_busy_q && pready_q && paddr == `SER_OFF_DATA |-> pslverr_q &&
        prdata_q == 32'h0000_0000)
        else $error("data register reachable while busy");

    start_enable_a : assert property (@(posedge core_clk) disable iff (rst)
        wr_en && paddr == `SER_OFF_PROTO && pwdata[`SER_PROTO_START]
        |=> bus_protocol_enable_q)
        else $error("start request did not force enable");

    verify_set_a : assert property (@(posedge core_clk) disable iff (rst)
        busy_set |=> verify_q && !ack_missing_q)
        else $error("verify or ack missing wrong at byte start");

    shift_noack_a : assert property (@(posedge core_clk) disable iff (rst)
        !bus_mode && byte_busy_q |-> state_q != serial_if_pkg::ST_ACK &&
        state_q != serial_if_pkg::ST_START)
        else $error("shift mode produced ack or start");

    last_noack_a : assert property (@(posedge core_clk) disable iff (rst)
        state_q == serial_if_pkg::ST_ACK && !transfer_direction_alt_q &&
        stop_request_q |=> sda_hw_q)
        else $error("ack driven on last received byte");

    data_stable_a : assert property (@(posedge core_clk) disable iff (rst)
        state_q == serial_if_pkg::ST_BIT && $past(scl_hw_q) && scl_hw_q
        |-> $stable(sda_hw_q))
        else $error("data moved while clock high");

    ser_idle_a : assert property (@(posedge core_clk) disable iff (rst)
        state_q == serial_if_pkg::ST_IDLE ##1
        state_q == serial_if_pkg::ST_IDLE |-> scl_hw_q && sda_hw_q &&
        sen_hw_q)
        else $error("lines not released while idle");

    qtr_bound_a : assert property (@(posedge core_clk) disable iff (rst)
        qcnt_q <= 12'(QTR_CYCLES - 1))
        else $error("bit divider overran");

endmodule

// ===== tb/serial_peer.sv
// bus partner: open-drain peripheral that acks, sends bytes and stretches
`timescale 1ns/100ps
module serial_peer
(
    input  wire logic       scl_oe,
    input  wire logic       sda_oe,
    input  wire logic       ack_en,
    input  wire logic       tx_en,
    input  wire logic       stretch,
    input  wire logic [7:0] tx_byte,
    output logic            scl,
    output logic            sda,
    output logic [7:0]      rx_byte,
    output logic            ack_seen
);
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    int   cnt     = 9;
    // pull-ups: a released line reads high
    assign scl = !scl_oe && !scl_low;
    assign sda = !sda_oe && !sda_low;
    ////////////////////////////////////////////////////////////////////////
    // a start condition opens a new byte count
    always @(negedge sda)
        if (scl)
            cnt = 0;
    always @(posedge scl)
    begin
        if (cnt < 8)
            rx_byte = {rx_byte[6:0], sda};
        if (cnt == 8)
            ack_seen = !sda;
        cnt = cnt + 1;
    end
    // lines are only changed while the clock is low
    always @(negedge scl)
    begin
        sda_low = (cnt == 8) ? ack_en
                : (cnt < 8 && tx_en && !tx_byte[7 - cnt]);
        if (stretch)
        begin
            scl_low = 1'b1;
            scl_low <= #200 1'b0;
        end
    end
endmodule

// ===== tb/single_master_serial_interface_tb.sv
// self-checking bench for the single-master serial interface
`timescale 1ns/100ps
`include "serial_if_consts.svh"
module single_master_serial_interface_tb;
    typedef struct packed
    {
        logic        wr;
        logic [11:0] a;
        logic [7:0]  d;
        logic [7:0]  r;
        logic        e;
    } row_t;
    logic                      core_clk = 1'b0;
    logic                      rst      = 1'b1;
    logic                      psel     = 1'b0;
    logic                      penable  = 1'b0;
    logic                      pwrite   = 1'b0;
    logic [11:0]               paddr    = 12'h000;
    logic [31:0]               pwdata   = 32'h0;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      p0 = 1'b1;
    logic                      p1 = 1'b1;
    logic                      p3 = 1'b1;
    logic                      scl;
    logic                      sda;
    serial_if_pkg::pin_drive_t scl_pin;
    serial_if_pkg::pin_drive_t sda_pin;
    serial_if_pkg::pin_drive_t sfe_pin;
    logic                      vsync_irq_enable;
    logic                      ack_en  = 1'b1;
    logic                      tx_en   = 1'b0;
    logic                      stretch = 1'b0;
    logic [7:0]                tx_byte = 8'h00;
    logic [7:0]                rx_byte;
    logic                      ack_seen;
    logic                      en_seen = 1'b0;
    logic                      en_clr  = 1'b0;
    logic [31:0]               rd;
    logic                      err;
    int                        cyc = 0;
    int                        mismatches = 0;
    int                        cmp_count = 0;
    row_t rows [11] = '{
        '{1'h0, 12'h004, 8'h00, 8'h00, 1'h0},
        '{1'h0, 12'h008, 8'h00, 8'h00, 1'h0},
        '{1'h1, 12'h004, 8'h01, 8'h00, 1'h0},
        '{1'h0, 12'h004, 8'h00, 8'h01, 1'h0},
        '{1'h1, 12'h004, 8'h08, 8'h00, 1'h0},
        '{1'h0, 12'h004, 8'h00, 8'h0A, 1'h0},
        '{1'h1, 12'h004, 8'h04, 8'h00, 1'h0},
        '{1'h0, 12'h004, 8'h00, 8'h06, 1'h0},
        '{1'h1, 12'h000, 8'hA5, 8'h00, 1'h0},
        '{1'h0, 12'h000, 8'h00, 8'hA5, 1'h0},
        '{1'h0, 12'h00C, 8'h00, 8'h00, 1'h1}};
    serial_if #(.QTR_CYCLES(8)) u_dut (.core_clk(core_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_c_line_0(p0), .port_c_line_1(p1),
        .port_c_line_3(p3), .scl_i(scl), .sda_i(sda), .scl_pin(scl_pin),
        .sda_pin(sda_pin), .serial_frame_enable_line(sfe_pin),
        .vsync_irq_enable(vsync_irq_enable));
    serial_peer u_peer (.scl_oe(scl_pin.oe), .sda_oe(sda_pin.oe),
        .ack_en(ack_en), .tx_en(tx_en), .stretch(stretch),
        .tx_byte(tx_byte), .scl(scl), .sda(sda), .rx_byte(rx_byte),
        .ack_seen(ack_seen));
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk)
        cyc <= cyc + 1;
    always @(posedge core_clk)
        if (sfe_pin.oe)
            en_seen <= 1'b1;
        else if (en_clr)
            en_seen <= 1'b0;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (mismatches == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one apb transfer; entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // set protocol and data, start one byte, poll busy, check its length
    task automatic run(input logic [7:0] pr, dat, xf, input int lo, hi);
        int t0;
        apb(1'b1, `SER_OFF_PROTO, {24'h0, pr});
        apb(1'b1, `SER_OFF_DATA, {24'h0, dat});
        apb(1'b1, `SER_OFF_XFER, {24'h0, xf});
        t0 = cyc;
        apb(1'b0, `SER_OFF_DATA, 32'h0);
        chk(err, 1'b1);
        apb(1'b0, `SER_OFF_XFER, 32'h0);
        chk(rd[1:0], 2'h1);
        while (rd[0] === 1'b1)
            apb(1'b0, `SER_OFF_XFER, 32'h0);
        chk(cyc - t0 >= lo && cyc - t0 <= hi, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        complete_run();
    end
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk({pready, pslverr, vsync_irq_enable}, 3'h0);
        chk({scl_pin, sda_pin, sfe_pin}, 6'h00);
        p0 <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(scl_pin.oe, 1'b1);
        p0 <= 1'b1;
        @(posedge core_clk);
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].a, {24'h0, rows[i].d});
            chk({err, rd[7:0] & {8{!rows[i].wr}}},
                {rows[i].e, rows[i].r});
        end
        apb(1'b1, `SER_OFF_XFER, 32'h4);
        chk(vsync_irq_enable, 1'b1);
        apb(1'b1, `SER_OFF_XFER, 32'h0);
        chk(vsync_irq_enable, 1'b0);
        run(8'h0E, 8'hA5, 8'h09, 348, 376);
        chk(rx_byte, 8'hA5);
        apb(1'b0, `SER_OFF_XFER, 32'h0);
        chk(rd[2:0], 3'h4);
        ack_en <= 1'b0;
        run(8'h0E, 8'h3C, 8'h09, 348, 376);
        apb(1'b0, `SER_OFF_XFER, 32'h0);
        chk(rd[1], 1'b1);
        tx_en   <= 1'b1;
        tx_byte <= 8'h7F;
        run(8'h0E, 8'hFF, 8'h09, 348, 376);
        apb(1'b0, `SER_OFF_XFER, 32'h0);
        chk(rd[2], 1'b0);
        tx_byte <= 8'hC3;
        run(8'h0A, 8'h00, 8'h01, 316, 344);
        chk(ack_seen, 1'b1);
        apb(1'b0, `SER_OFF_DATA, 32'h0);
        chk(rd[7:0], 8'hC3);
        tx_byte <= 8'h5A;
        run(8'h0E, 8'h00, 8'h01, 348, 376);
        chk(ack_seen, 1'b0);
        apb(1'b0, `SER_OFF_DATA, 32'h0);
        chk(rd[7:0], 8'h5A);
        tx_en  <= 1'b0;
        ack_en <= 1'b1;
        run(8'h0F, 8'h55, 8'h09, 348, 376);
        chk(en_seen, 1'b1);
        en_clr <= 1'b1;
        @(posedge core_clk);
        en_clr <= 1'b0;
        run(8'h01, 8'h96, 8'h09, 252, 280);
        chk(en_seen, 1'b0);
        stretch <= 1'b1;
        run(8'h0E, 8'hA5, 8'h09, 560, 1000);
        stretch <= 1'b0;
        apb(1'b1, `SER_OFF_PROTO, 32'hE);
        apb(1'b1, `SER_OFF_XFER, 32'h9);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        apb(1'b0, `SER_OFF_XFER, 32'h0);
        chk(rd[3:0], 4'h0);
        apb(1'b0, `SER_OFF_PROTO, 32'h0);
        chk(rd[3:0], 4'h0);
        complete_run();
    end
endmodule
